// ==== core/asp_params.svh ====
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Control byte framing
// ----------------------------------------------------------------------------
`define ASP_CTRL_BITS 4'd8
`define ASP_TRACK_BIT 4'd5
`define ASP_BIP_BIT 3
`define ASP_CTRL_RST 8'h00

// ----------------------------------------------------------------------------
// Result frame
// ----------------------------------------------------------------------------
`define ASP_LEAD_ZEROS 3
`define ASP_STRB_STEP 0

`endif

// ==== core/asp_pkg.sv ====
package asp_pkg;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic shutdown_n;
    } asp_pins_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ASP_IDLE = 2'b00,
        ASP_CTRL = 2'b01,
        ASP_CONV = 2'b10
    } asp_state_t;

endpackage

// ==== core/asp_serial_port.sv ====
`timescale 1ns/1ps
`include "asp_params.svh"
// Behaviour
// - Sample serial input on serial clock rise.
// - No shifting while chip select is high.
// - Serial output changes on serial clock rise.
// - Outputs released while chip select is high.
// - Strobe high for one period, three periods before MSB decision.
// - Shutdown low stops all conversion activity.
// - Each serial clock paces one conversion step.
// - Leading zeros skipped, first one starts byte.
// - Track after fifth bit, hold after eighth.
// - Result sent MSB first, bipolar two's complement.
// - Frame: three zeros, result, sub-bits, zero.
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int RES_BITS = 10,
    parameter int SUB_BITS = 2
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic shutdown_n,
    input wire logic [RES_BITS+SUB_BITS-1:0] adc_code,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe,
    output logic strobe_oe,
    output logic track,
    output logic hold,
    output logic powered_down,
    output logic [7:0] ctrl_byte,
    output logic ctrl_valid
);

    localparam int CW = RES_BITS + SUB_BITS;
    localparam int FW = CW + `ASP_LEAD_ZEROS + 1;
    localparam int SW = $clog2(FW);
    localparam logic [SW-1:0] STEP_LAST = SW'(FW - 1);
    localparam logic [SW-1:0] STEP_STRB = SW'(`ASP_STRB_STEP);
    localparam logic [SW-1:0] STEP_MSB = SW'(`ASP_LEAD_ZEROS);
    localparam asp_pins_t PINS_RST = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, shutdown_n: 1'b0};

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    asp_pins_t pin_raw;
    asp_pins_t meta_q;
    asp_pins_t sync_q;
    logic sclk_prev_q;

    assign pin_raw = '{sclk: sclk, cs_n: cs_n, din: din, shutdown_n: shutdown_n};

    // Two flops per pin, then a third sclk flop for edge finding.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= PINS_RST;
            sync_q <= PINS_RST;
            sclk_prev_q <= 1'b0;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            sclk_prev_q <= sync_q.sclk;
        end
    end

    // ------------------------------------------------------------------------
    // Edge and event decode
    // ------------------------------------------------------------------------
    asp_state_t state_q;
    asp_state_t state_d;
    logic [7:0] shreg_q;
    logic [3:0] cnt_q;
    logic [SW-1:0] step_q;
    logic [CW-1:0] code_q;
    logic [FW-1:0] frame;
    logic [SW-1:0] bit_idx;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_s;
    logic shut;
    logic go;
    logic start_bit;
    logic ctrl_shift;
    logic track_go;
    logic hold_go;
    logic conv_step;
    logic frame_end;
    logic bipolar;
    logic [CW-1:0] code_enc;

    assign sclk_rise = sync_q.sclk & ~sclk_prev_q;
    assign sclk_fall = ~sync_q.sclk & sclk_prev_q;
    assign cs_s = sync_q.cs_n;
    assign shut = ~sync_q.shutdown_n;
    assign go = ~shut & ~cs_s;
    assign start_bit = go & sclk_rise & (state_q == ASP_IDLE) & sync_q.din;
    assign ctrl_shift = go & sclk_rise & (state_q == ASP_CTRL) & (cnt_q != `ASP_CTRL_BITS);
    assign track_go = go & sclk_fall & (state_q == ASP_CTRL) & (cnt_q == `ASP_TRACK_BIT);
    assign hold_go = go & sclk_fall & (state_q == ASP_CTRL) & (cnt_q == `ASP_CTRL_BITS);
    assign conv_step = go & sclk_rise & (state_q == ASP_CONV);
    assign frame_end = conv_step & (step_q == STEP_LAST);

    // Bipolar code flips its top bit into two's complement.
    assign bipolar = shreg_q[`ASP_BIP_BIT];
    assign code_enc = bipolar ? {~adc_code[CW-1], adc_code[CW-2:0]} : adc_code;
    assign frame = {{`ASP_LEAD_ZEROS{1'b0}}, code_q, 1'b0};
    assign bit_idx = STEP_LAST - step_q;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // Next state; chip select high or shutdown abandons any transfer.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ASP_IDLE: begin
                if (start_bit) begin
                    state_d = ASP_CTRL;
                end
            end
            ASP_CTRL: begin
                if (hold_go) begin
                    state_d = ASP_CONV;
                end
            end
            ASP_CONV: begin
                if (frame_end) begin
                    state_d = ASP_IDLE;
                end
            end
            default: state_d = ASP_IDLE;
        endcase
        if (!go) begin
            state_d = ASP_IDLE;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ASP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Control byte shift register and bit counter.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_q <= `ASP_CTRL_RST;
            cnt_q <= 4'd0;
        end else if (start_bit) begin
            shreg_q <= 8'h01;
            cnt_q <= 4'd1;
        end else if (ctrl_shift) begin
            shreg_q <= {shreg_q[6:0], sync_q.din};
            cnt_q <= cnt_q + 4'd1;
        end
    end

    // Sample capture and step counter.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= '0;
            step_q <= '0;
        end else if (hold_go) begin
            code_q <= code_enc;
            step_q <= '0;
        end else if (conv_step) begin
            step_q <= step_q + SW'(1);
        end
    end

    // ------------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------------
    logic dout_q;
    logic dout_oe_q;
    logic strobe_q;
    logic strobe_oe_q;

    // Output bit moves only on a serial clock rise.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= 1'b0;
        end else if (go && sclk_rise) begin
            dout_q <= conv_step & frame[bit_idx];
        end
    end

    // Strobe spans the first conversion period.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b0;
        end else if (!go) begin
            strobe_q <= 1'b0;
        end else if (sclk_rise) begin
            strobe_q <= conv_step & (step_q == STEP_STRB);
        end
    end

    // Drivers enabled only with chip select low.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_oe_q <= 1'b0;
            strobe_oe_q <= 1'b0;
        end else begin
            dout_oe_q <= ~cs_s;
            strobe_oe_q <= ~cs_s;
        end
    end

    // ------------------------------------------------------------------------
    // Track/hold, status and control byte
    // ------------------------------------------------------------------------
    logic track_q;
    logic hold_q;
    logic pd_q;
    logic [7:0] ctrl_byte_q;
    logic ctrl_valid_q;

    // Track from fifth bit, hold from eighth until the frame ends.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            track_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (!go) begin
            track_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (hold_go) begin
            track_q <= 1'b0;
            hold_q <= 1'b1;
        end else if (track_go) begin
            track_q <= 1'b1;
        end else if (frame_end) begin
            hold_q <= 1'b0;
        end
    end

    // Shutdown flag and control byte hand-off.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pd_q <= 1'b1;
            ctrl_byte_q <= `ASP_CTRL_RST;
            ctrl_valid_q <= 1'b0;
        end else begin
            pd_q <= shut;
            ctrl_valid_q <= hold_go;
            if (hold_go) begin
                ctrl_byte_q <= shreg_q;
            end
        end
    end

    assign dout = dout_q;
    assign dout_oe = dout_oe_q;
    assign conversion_strobe = strobe_q;
    assign strobe_oe = strobe_oe_q;
    assign track = track_q;
    assign hold = hold_q;
    assign powered_down = pd_q;
    assign ctrl_byte = ctrl_byte_q;
    assign ctrl_valid = ctrl_valid_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_shreg_on_rise: assert property ($changed(shreg_q) |-> $past(sclk_rise))
        else $error("Shift register moved without a serial clock rise.");
    a_cs_no_shift: assert property (cs_s |=> $stable(shreg_q) && $stable(cnt_q))
        else $error("Bits shifted while chip select was high.");
    a_dout_on_rise: assert property ($changed(dout_q) |-> $past(sclk_rise))
        else $error("Serial output changed off a serial clock rise.");
    a_cs_release: assert property (cs_s |=> !dout_oe_q && !strobe_oe_q)
        else $error("Outputs driven while chip select high.");
    a_strobe_start: assert property ($rose(strobe_q) |-> $past(conv_step) && $past(step_q) == STEP_STRB)
        else $error("Strobe rose at the wrong step.");
    a_strobe_one_period: assert property (strobe_q && sclk_rise |=> !strobe_q)
        else $error("Strobe lasted beyond one serial clock period.");
    a_shut_stops: assert property (shut |=> state_q == ASP_IDLE && !hold_q && pd_q)
        else $error("Conversion continued in shutdown.");
    a_step_paced: assert property ($changed(step_q) |-> $past(sclk_rise) || $past(hold_go))
        else $error("Conversion step without a serial clock.");
    a_zero_ignored: assert property (state_q == ASP_IDLE && !start_bit |=> state_q == ASP_IDLE)
        else $error("Left idle without a start bit.");
    a_track_fifth: assert property ($rose(track_q) |-> $past(sclk_fall) && $past(cnt_q) == 4'd5)
        else $error("Tracking began at the wrong bit.");
    a_hold_eighth: assert property ($rose(hold_q) |-> $past(sclk_fall) && $past(cnt_q) == 4'd8)
        else $error("Hold began at the wrong bit.");
    a_msb_first: assert property (conv_step && step_q == STEP_MSB |=> dout_q == code_q[CW-1])
        else $error("First result bit was not the MSB.");
    a_lead_zeros: assert property (conv_step && step_q < STEP_MSB |=> !dout_q)
        else $error("Leading frame bit was not zero.");

    c_hold: cover property (hold_go);
    c_frame_end: cover property (frame_end);
    c_shut_mid_conv: cover property (state_q == ASP_CONV && shut);
    c_cs_abort: cover property (state_q == ASP_CTRL && cs_s);

endmodule

// ==== dv/asp_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host serial master
// ----------------------------------------------------------------------------
module asp_host_model (
    input wire logic mclk,
    input wire logic miso,
    input wire logic strb,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // The link clock is parked low and the device deselected between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Moves chip select and leaves four clocks of setup before any edge.
    task automatic set_cs(input logic v);
        @(posedge mclk);
        #1 cs_n = v;
        repeat (4) @(posedge mclk);
    endtask

    // Shifts n bits MSB first at 160 ns per bit, capturing output and strobe.
    task automatic shift(input int n, input logic [23:0] tx, output logic [23:0] rx,
                         output logic [23:0] st);
        rx = '0;
        st = '0;
        @(posedge mclk);
        #1;
        for (int i = n - 1; i >= 0; i--) begin
            din = tx[i];
            repeat (4) @(posedge mclk);
            #1 sclk = 1'b1;
            repeat (4) @(posedge mclk);
            #1;
            rx[i] = miso;
            st[i] = strb;
            sclk = 1'b0;
        end
        // A released data line does not keep its last level.
        din = ~din;
    endtask
endmodule

// ==== dv/tb_asp_serial_port.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bench for the converter serial port
// ----------------------------------------------------------------------------
module tb_asp_serial_port;
    import asp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic shutdown_n = 1'b1;
    logic [11:0] adc_code = 12'h000;
    logic sclk, cs_n, din, dout, dout_oe, conversion_strobe, strobe_oe;
    logic track, hold, powered_down, ctrl_valid, pad_q, miso, strb;
    logic [7:0] ctrl_byte;
    logic [23:0] rx, st;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    // Undriven pins show a level that changes every cycle.
    always #10 mclk = ~mclk;
    initial pad_q = 1'b0;
    always @(posedge mclk) pad_q <= ~pad_q;
    assign miso = dout_oe ? dout : pad_q;
    assign strb = strobe_oe ? conversion_strobe : pad_q;

    asp_serial_port u_asp_serial_port (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .shutdown_n(shutdown_n), .adc_code(adc_code), .dout(dout),
        .dout_oe(dout_oe), .conversion_strobe(conversion_strobe), .strobe_oe(strobe_oe),
        .track(track), .hold(hold), .powered_down(powered_down), .ctrl_byte(ctrl_byte),
        .ctrl_valid(ctrl_valid));
    asp_host_model u_asp_host_model (.mclk(mclk), .miso(miso), .strb(strb), .sclk(sclk),
        .cs_n(cs_n), .din(din));

    // Counts one comparison and reports a failing one.
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Full conversion: zeros, control byte in two parts, then the result frame.
    task automatic conv_case(input logic [7:0] ctl, input logic [11:0] code);
        logic [15:0] exp;
        exp = ctl[3] ? {3'b000, ~code[11], code[10:0], 1'b0} : {3'b000, code, 1'b0};
        adc_code = code;
        u_asp_host_model.set_cs(1'b0);
        chk(dout_oe === 1'b1 && strobe_oe === 1'b1, "outputs not driven");
        u_asp_host_model.shift(3, 24'h000000, rx, st);
        u_asp_host_model.shift(6, {18'h0, ctl[7:2]}, rx, st);
        repeat (5) @(posedge mclk);
        chk(track === 1'b1 && hold === 1'b0, "no tracking after bit five");
        u_asp_host_model.shift(2, {22'h0, ctl[1:0]}, rx, st);
        // The fall after bit eight reaches the event logic on the second edge; the control byte pulse shows after the third.
        repeat (3) @(posedge mclk);
        #1;
        chk(ctrl_valid === 1'b1, "no control byte pulse");
        @(posedge mclk);
        #1;
        chk(ctrl_valid === 1'b0, "control byte pulse too long");
        chk(hold === 1'b1 && track === 1'b0, "no hold after bit eight");
        chk(ctrl_byte === ctl, "control byte wrong");
        u_asp_host_model.shift(16, 24'h000000, rx, st);
        chk(rx[15:0] === exp, "result frame wrong");
        chk(st[15:0] === 16'h8000, "strobe not in first period only");
        repeat (5) @(posedge mclk);
        chk(hold === 1'b0, "conversion not done after frame");
        u_asp_host_model.set_cs(1'b1);
        chk(dout_oe === 1'b0 && strobe_oe === 1'b0, "outputs not released");
    endtask

    // Partial byte, deselected clocks, then a fresh byte that needs its own start bit.
    task automatic abort_case();
        u_asp_host_model.set_cs(1'b0);
        u_asp_host_model.shift(4, 24'h000008, rx, st);
        u_asp_host_model.set_cs(1'b1);
        u_asp_host_model.shift(8, 24'h0000ff, rx, st);
        repeat (5) @(posedge mclk);
        chk(track === 1'b0 && hold === 1'b0, "bits taken while deselected");
        u_asp_host_model.set_cs(1'b0);
        u_asp_host_model.shift(8, 24'h000091, rx, st);
        repeat (5) @(posedge mclk);
        chk(ctrl_byte === 8'h91 && hold === 1'b1, "partial byte kept");
        u_asp_host_model.set_cs(1'b1);
        chk(hold === 1'b0, "deselect did not abort");
    endtask

    // Shutdown in mid-conversion stops it while the host keeps clocking.
    task automatic shutdown_case();
        u_asp_host_model.set_cs(1'b0);
        u_asp_host_model.shift(12, 24'h000800, rx, st);
        @(posedge mclk);
        #1 shutdown_n = 1'b0;
        repeat (4) @(posedge mclk);
        chk(powered_down === 1'b1 && hold === 1'b0, "shutdown ignored");
        u_asp_host_model.shift(4, 24'h000000, rx, st);
        chk(st[3:0] === 4'h0 && hold === 1'b0, "activity in shutdown");
        @(posedge mclk);
        #1 shutdown_n = 1'b1;
        repeat (4) @(posedge mclk);
        chk(powered_down === 1'b0, "no wake from shutdown");
        u_asp_host_model.set_cs(1'b1);
    endtask

    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk);
        chk(powered_down === 1'b1 && dout_oe === 1'b0, "reset values wrong");
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        conv_case(8'h80, 12'h5a7);
        conv_case(8'h88, 12'h3c5);
        abort_case();
        shutdown_case();
        conv_case(8'hf7, 12'hfff);
        test_done();
    end

    // Cuts a hang short.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end
endmodule
